// File: design/bififo_consts.vh
`ifndef BIFIFO_CONSTS_VH
`define BIFIFO_CONSTS_VH

`define WORD_W        18
`define OFS_W         9
`define OFFSET_RESET  9'h008
`define FLAGS_RESET   4'h3

`define ADDR_DATA     8'h00
`define ADDR_BYPASS   8'h04
`define ADDR_AB_AE    8'h10
`define ADDR_AB_AF    8'h14
`define ADDR_BA_AE    8'h18
`define ADDR_BA_AF    8'h1c
`define ADDR_CTRL     8'h20
`define ADDR_STATUS   8'h24

`define CTRL_RESET    4'h1
`define CTRL_SEL_BIT  0
`define CTRL_RES_LSB  1
`define CTRL_RES_MSB  3
`define RES_BYPASS    3'b001

`define ST_BYPASS_BIT 8
`define ST_ABBYP_BIT  9
`define ST_BABYP_BIT  10

`endif

// File: design/bififo_port_b.v
`timescale 1ns/1ps
`include "bififo_consts.vh"

// Function
// - Empty low at 0, full low at D
// - Almost flags low within programmed offsets
// - Depth D is 256 or 512 words
// - Port B write captures data into FIFO
// - Read direction drives output register unless drive off
// - Word enable high ignores data, holds output
// - Word enable high never advances read pointer
// - Sampled low direction forces lines undriven
// - FIFO-mode read loads next word, advances pointer
// - Bypass-mode read delivers the bypass word
// - Bypass writes move words to opposite register
// - Deselecting Port A ends bypass next edge
// - Bypass indicator rise clears all bypass flags
// - Port B gets one cycle for last bypass
// - Flag updates may lag one edge
// - Extra first-word latency only when empty
// - Offsets reset to eight
// - Flags registered in the consuming domain; here all flags are registered on CLK_SYS
module bififo_port_b #(
  parameter AW    = 9,
  parameter DEPTH = 512
) (
  input  wire        CLK_SYS,
  input  wire        RESET,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        PORT_B_CLOCK,
  input  wire        PORT_B_DIRECTION,
  input  wire        PORT_B_WORD_ENABLE_N,
  input  wire        PORT_B_OUTPUT_DRIVE_N,
  input  wire [17:0] PORT_B_DATA_IN,
  output reg  [17:0] PORT_B_DATA_OUT,
  output reg         PORT_B_DATA_OE,
  output wire        AB_EMPTY_FLAG_N,
  output wire        AB_ALMOST_EMPTY_FLAG_N,
  output wire        AB_ALMOST_FULL_FLAG_N,
  output wire        AB_FULL_FLAG_N,
  output wire        BA_EMPTY_FLAG_N,
  output wire        BA_ALMOST_EMPTY_FLAG_N,
  output wire        BA_ALMOST_FULL_FLAG_N,
  output wire        BA_FULL_FLAG_N,
  output reg         BYPASS_ACTIVE_TO_B_N
);

  localparam [AW:0] depth_w = DEPTH[AW:0];

  // Returns {empty_n, almost_empty_n, almost_full_n, full_n}
  // Integers keep the depth arithmetic clear of width wrap
  function [3:0] flag_code;
    input [AW:0]        c;
    input [`OFS_W-1:0]  n;
    input [`OFS_W-1:0]  m;
    integer ci;
    integer ni;
    integer mi;
    integer di;
    begin
      ci = c;
      ni = n;
      mi = m;
      di = depth_w;
      flag_code[3] = (ci != 0);
      flag_code[2] = (ci > ni);
      flag_code[1] = (ci < di - mi);
      flag_code[0] = (ci != di);
    end
  endfunction

  // Port B pins come from another domain, including its clock
  // Sampling the clock pin as data costs three system clocks of latency,
  // but keeps the whole block in one clock domain
  reg  [21:0]        bs1;
  reg  [21:0]        bs2;
  reg                bclk_d;
  wire               bclk    = bs2[21];
  wire               bdir    = bs2[20];
  wire               ben_n   = bs2[19];
  wire               boe_n   = bs2[18];
  wire [17:0]        bdata   = bs2[17:0];
  wire               b_edge  = bclk & ~bclk_d;
  wire               b_wr    = b_edge & ~bdir & ~ben_n;
  wire               b_rd    = b_edge & bdir & ~ben_n;

  reg  [3:0]         ctrl;
  reg  [`OFS_W-1:0]  ab_ae_off;
  reg  [`OFS_W-1:0]  ab_af_off;
  reg  [`OFS_W-1:0]  ba_ae_off;
  reg  [`OFS_W-1:0]  ba_af_off;
  reg  [17:0]        in_reg;
  reg                dir_hold;
  reg  [17:0]        ab_byp_word;
  reg                ab_byp_full;
  reg  [17:0]        ba_byp_word;
  reg                ba_byp_full;
  reg                pend_take;
  reg                ba_push_q;

  // Flat buses collect the per-direction values of the generate loop
  wire [1:0]         push;
  wire [1:0]         pop;
  wire [35:0]        din;
  wire [35:0]        head;
  wire [2*AW+1:0]    cnt;
  wire [7:0]         flags;

  // Port A sits in bypass only while selected with the bypass resource
  wire mode_bypass = ~ctrl[`CTRL_SEL_BIT] &
                     (ctrl[`CTRL_RES_MSB:`CTRL_RES_LSB] == `RES_BYPASS);
  wire b_byp       = ~BYPASS_ACTIVE_TO_B_N;
  wire byp_exit    = b_edge & b_byp & ~mode_bypass;
  wire setup       = PSEL & ~PENABLE;
  wire acc         = PSEL & PENABLE & PREADY;
  wire acc_wr      = acc & PWRITE;
  wire ab_ef_n     = flags[3];
  wire ba_ef_n     = flags[7];

  assign AB_EMPTY_FLAG_N        = flags[3];
  assign AB_ALMOST_EMPTY_FLAG_N = flags[2];
  assign AB_ALMOST_FULL_FLAG_N  = flags[1];
  assign AB_FULL_FLAG_N         = flags[0];
  assign BA_EMPTY_FLAG_N        = flags[7];
  assign BA_ALMOST_EMPTY_FLAG_N = flags[6];
  assign BA_ALMOST_FULL_FLAG_N  = flags[5];
  assign BA_FULL_FLAG_N         = flags[4];

  // Index 0 is A-to-B (APB fills, Port B drains), 1 is B-to-A
  // A write to a full FIFO is dropped; software is expected to watch full
  assign push[0] = acc_wr & (PADDR == `ADDR_DATA) & (cnt[AW:0] != depth_w);
  assign pop[0]  = b_rd & ~b_byp & ab_ef_n;
  // Port B words are staged in the input register and reach memory a clock later
  assign push[1] = ba_push_q;
  assign pop[1]  = acc & ~PWRITE & pend_take & (PADDR == `ADDR_DATA);
  assign din     = {in_reg, PWDATA[17:0]};

  // Both directions share one FIFO body; only the push, pop, data and offset hookups differ
  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1)
    begin : g_fifo
      reg [17:0]   mem [0:DEPTH-1];
      reg [AW-1:0] wp;
      reg [AW-1:0] rp;
      reg [AW:0]   count;
      reg [3:0]    fl;
      wire [`OFS_W-1:0] n_off = (k == 0) ? ab_ae_off : ba_ae_off;
      wire [`OFS_W-1:0] m_off = (k == 0) ? ab_af_off : ba_af_off;

      always @(posedge CLK_SYS)
      begin
        if (push[k])
          mem[wp] <= din[18*k+17:18*k];
      end

      always @(posedge CLK_SYS)
      begin
        if (RESET)
        begin
          wp    <= {AW{1'b0}};
          rp    <= {AW{1'b0}};
          count <= {(AW+1){1'b0}};
          // Reset shows an empty FIFO so no read is taken before a write
          fl    <= `FLAGS_RESET;
        end
        else
        begin
          if (push[k])
            wp <= wp + 1'b1;
          if (pop[k])
            rp <= rp + 1'b1;
          if (push[k] & ~pop[k])
            count <= count + 1'b1;
          else if (pop[k] & ~push[k])
            count <= count - 1'b1;
          // Flags follow the count one clock later, so a word written
          // into an empty FIFO is readable only after that clock
          fl <= flag_code(count, n_off, m_off);
        end
      end

      assign head[18*k+17:18*k]           = mem[rp];
      assign cnt[(AW+1)*k+AW:(AW+1)*k]    = count;
      assign flags[4*k+3:4*k]             = fl;
    end
  endgenerate

  always @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      // Idle clock pin level is low, so no false Port B edge follows reset
      bs1    <= 22'h000000;
      bs2    <= 22'h000000;
      bclk_d <= 1'b0;
    end
    else
    begin
      bs1    <= {PORT_B_CLOCK, PORT_B_DIRECTION, PORT_B_WORD_ENABLE_N,
                 PORT_B_OUTPUT_DRIVE_N, PORT_B_DATA_IN};
      bs2    <= bs1;
      bclk_d <= bs2[21];
    end
  end

  // Port B data path and bypass handshake
  always @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      PORT_B_DATA_OUT      <= 18'h00000;
      PORT_B_DATA_OE       <= 1'b0;
      dir_hold             <= 1'b0;
      in_reg               <= 18'h00000;
      ba_push_q            <= 1'b0;
      BYPASS_ACTIVE_TO_B_N <= 1'b1;
      ab_byp_word          <= 18'h00000;
      ab_byp_full          <= 1'b0;
      ba_byp_word          <= 18'h00000;
      ba_byp_full          <= 1'b0;
    end
    else
    begin
      // Direction is latched per edge so the drivers follow the drive pin between edges
      if (b_edge)
        dir_hold <= bdir;
      // A low direction on a Port B edge turns the drivers off at once
      PORT_B_DATA_OE <= (b_edge ? bdir : dir_hold) & ~boe_n;
      if (b_wr)
        in_reg <= bdata;
      // Full is judged at the Port B edge; the next edge is at least two
      // clocks away, so the staged push always lands before it
      ba_push_q <= b_wr & ~b_byp & (cnt[2*AW+1:AW+1] != depth_w);
      if (b_edge)
        BYPASS_ACTIVE_TO_B_N <= ~mode_bypass;
      // A read of an empty FIFO leaves the output register as it was
      if (pop[0])
        PORT_B_DATA_OUT <= head[17:0];
      // The indicator is still low on the exit edge, which is the
      // single cycle Port B has left to take the held word
      else if (b_rd & b_byp & ab_byp_full)
        PORT_B_DATA_OUT <= ab_byp_word;
      // The exit edge frees both bypass words for the next bypass
      if (byp_exit)
      begin
        ab_byp_full <= 1'b0;
        ba_byp_full <= 1'b0;
      end
      else
      begin
        if (acc_wr & (PADDR == `ADDR_BYPASS) & mode_bypass & ~ab_byp_full)
        begin
          ab_byp_word <= PWDATA[17:0];
          ab_byp_full <= 1'b1;
        end
        else if (b_rd & b_byp & ab_byp_full)
          ab_byp_full <= 1'b0;
        if (b_wr & b_byp & ~ba_byp_full)
        begin
          ba_byp_word <= bdata;
          ba_byp_full <= 1'b1;
        end
        else if (acc & ~PWRITE & pend_take & (PADDR == `ADDR_BYPASS))
          ba_byp_full <= 1'b0;
      end
    end
  end

  // APB slave: zero wait states, read data prepared in setup
  // Writes take effect only at the access edge, never in setup
  always @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      PREADY    <= 1'b0;
      PSLVERR   <= 1'b0;
      PRDATA    <= 32'h00000000;
      pend_take <= 1'b0;
      ctrl      <= `CTRL_RESET;
      ab_ae_off <= `OFFSET_RESET;
      ab_af_off <= `OFFSET_RESET;
      ba_ae_off <= `OFFSET_RESET;
      ba_af_off <= `OFFSET_RESET;
    end
    else
    begin
      PREADY <= setup;
      if (setup)
      begin
        PSLVERR   <= 1'b0;
        PRDATA    <= 32'h00000000;
        pend_take <= 1'b0;
        case (PADDR)
          `ADDR_DATA:
          begin
            // Pop only what setup found, so an empty read never moves a pointer
            pend_take <= ba_ef_n;
            if (ba_ef_n)
              PRDATA[17:0] <= head[35:18];
          end
          `ADDR_BYPASS:
          begin
            pend_take <= ba_byp_full;
            if (ba_byp_full)
              PRDATA[17:0] <= ba_byp_word;
          end
          `ADDR_AB_AE:  PRDATA[`OFS_W-1:0] <= ab_ae_off;
          `ADDR_AB_AF:  PRDATA[`OFS_W-1:0] <= ab_af_off;
          `ADDR_BA_AE:  PRDATA[`OFS_W-1:0] <= ba_ae_off;
          `ADDR_BA_AF:  PRDATA[`OFS_W-1:0] <= ba_af_off;
          `ADDR_CTRL:   PRDATA[3:0] <= ctrl;
          // Status packs both flag sets and the bypass state for polling
          `ADDR_STATUS: PRDATA[10:0] <= {ba_byp_full, ab_byp_full,
                                         BYPASS_ACTIVE_TO_B_N, flags};
          default:      PSLVERR <= 1'b1;
        endcase
      end
      // Offset writes keep bits 8..0 only; the rest read back as zero
      if (acc_wr)
      begin
        case (PADDR)
          `ADDR_AB_AE: ab_ae_off <= PWDATA[`OFS_W-1:0];
          `ADDR_AB_AF: ab_af_off <= PWDATA[`OFS_W-1:0];
          `ADDR_BA_AE: ba_ae_off <= PWDATA[`OFS_W-1:0];
          `ADDR_BA_AF: ba_af_off <= PWDATA[`OFS_W-1:0];
          `ADDR_CTRL:  ctrl <= PWDATA[3:0];
          default:     ctrl <= ctrl;
        endcase
      end
    end
  end

endmodule // bififo_port_b

// File: bench/bififo_port_b_sva.sv
`timescale 1ns/1ps
module bififo_port_b_sva (
  input logic        CLK_SYS,
  input logic        RESET,
  input logic        PORT_B_CLOCK,
  input logic        PORT_B_DIRECTION,
  input logic        PORT_B_WORD_ENABLE_N,
  input logic        PORT_B_OUTPUT_DRIVE_N,
  input logic [17:0] PORT_B_DATA_OUT,
  input logic        PORT_B_DATA_OE,
  input logic        AB_EMPTY_FLAG_N,
  input logic        AB_ALMOST_EMPTY_FLAG_N,
  input logic        AB_ALMOST_FULL_FLAG_N,
  input logic        AB_FULL_FLAG_N,
  input logic        BA_EMPTY_FLAG_N
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  a_reset_flags: assert property ($fell(RESET) |-> !AB_EMPTY_FLAG_N && !BA_EMPTY_FLAG_N && AB_FULL_FLAG_N)
    else $error("empty flags wrong after reset");
  a_full_not_empty: assert property (!AB_FULL_FLAG_N |-> AB_EMPTY_FLAG_N)
    else $error("full and empty together");
  a_empty_almost: assert property (!AB_EMPTY_FLAG_N [*2] |-> !AB_ALMOST_EMPTY_FLAG_N)
    else $error("almost-empty high while empty");
  a_full_almost: assert property (!AB_FULL_FLAG_N [*2] |-> !AB_ALMOST_FULL_FLAG_N)
    else $error("almost-full high while full");
  a_write_undriven: assert property ($rose(PORT_B_CLOCK) && !PORT_B_DIRECTION |-> ##[3:6] !PORT_B_DATA_OE)
    else $error("lines driven during write");
  a_drive_off: assert property ($rose(PORT_B_CLOCK) && PORT_B_OUTPUT_DRIVE_N |-> ##[3:6] !PORT_B_DATA_OE)
    else $error("lines driven with drive off");
  a_drive_on: assert property ($rose(PORT_B_CLOCK) && PORT_B_DIRECTION && !PORT_B_OUTPUT_DRIVE_N
    |-> ##[3:6] PORT_B_DATA_OE)
    else $error("read lines not driven");
  a_hold_disabled: assert property ($rose(PORT_B_CLOCK) && PORT_B_WORD_ENABLE_N
    |-> ##1 $stable(PORT_B_DATA_OUT) [*8])
    else $error("output changed while disabled");
endmodule // bififo_port_b_sva

// File: bench/port_b_agent.sv
`timescale 1ns/1ps
module port_b_agent (
  input  logic        clk,
  output logic        b_clock,
  output logic        b_dir,
  output logic        b_en_n,
  output logic        b_drv_n,
  output logic [17:0] b_data
);
  logic drove;
  initial
  begin
    b_clock = 1'b0;
    b_dir   = 1'b1;
    b_en_n  = 1'b1;
    b_drv_n = 1'b1;
    b_data  = 18'h0;
    drove   = 1'b0;
  end
  // Clock pin stands low between transfers; setup and high phases span five system cycles, the tail four
  task automatic one(input logic [2:0] c, input logic [17:0] d);
    @(posedge clk);
    b_dir   <= c[2];
    b_en_n  <= c[1];
    b_drv_n <= c[0];
    b_data  <= (c[2:1] == 2'b00) ? d : ~b_data;
    repeat (5) @(posedge clk);
    b_clock <= 1'b1;
    repeat (5) @(posedge clk);
    b_clock <= 1'b0;
    drove   <= c[2] && !c[0];
    repeat (4) @(posedge clk);
  endtask
  // c is {direction, word enable_n, drive_n}
  task automatic op(input logic [2:0] c, input logic [17:0] d);
    if (c[2:1] == 2'b00 && drove)
      one(3'b111, 18'h0);
    one(c, d);
  endtask
endmodule // port_b_agent

// File: bench/bififo_port_b_tb.sv
`timescale 1ns/1ps
`include "bififo_consts.vh"
module bififo_port_b_tb;
  logic        clk, rst, psel, penable, pwrite, err, pready, pslverr;
  logic        b_clk, b_dir, b_en_n, b_drv_n, oe, ab_e, ab_ae, ab_af, ab_f, ba_e, ba_ae, ba_af, ba_f, byp_n;
  logic [7:0]  paddr;
  logic [17:0] b_din, b_dout;
  logic [31:0] pwdata, prdata, rd;
  int          miscompares, comparisons;
  bififo_port_b #(.AW(8), .DEPTH(256)) bififo_port_b_i (
    .CLK_SYS(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PORT_B_CLOCK(b_clk), .PORT_B_DIRECTION(b_dir), .PORT_B_WORD_ENABLE_N(b_en_n),
    .PORT_B_OUTPUT_DRIVE_N(b_drv_n), .PORT_B_DATA_IN(b_din), .PORT_B_DATA_OUT(b_dout),
    .PORT_B_DATA_OE(oe), .AB_EMPTY_FLAG_N(ab_e), .AB_ALMOST_EMPTY_FLAG_N(ab_ae),
    .AB_ALMOST_FULL_FLAG_N(ab_af), .AB_FULL_FLAG_N(ab_f), .BA_EMPTY_FLAG_N(ba_e),
    .BA_ALMOST_EMPTY_FLAG_N(ba_ae), .BA_ALMOST_FULL_FLAG_N(ba_af), .BA_FULL_FLAG_N(ba_f),
    .BYPASS_ACTIVE_TO_B_N(byp_n));
  port_b_agent pb (.clk(clk), .b_clock(b_clk), .b_dir(b_dir), .b_en_n(b_en_n),
    .b_drv_n(b_drv_n), .b_data(b_din));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the watchdog ends a wait for ready
    while (pready !== 1'b1)
      @(posedge clk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic fl(input logic [3:0] e);
    repeat (3) @(posedge clk);
    chk({28'h0, ab_e, ab_ae, ab_af, ab_f}, {28'h0, e});
  endtask
  task automatic t_reset;
    fl(4'b0011);
    apb(1'b0, `ADDR_AB_AE, 32'h0);
    chk(rd, 32'h8);
    chk(32'(err), 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, `ADDR_AB_AE, 32'h3fe02);
    apb(1'b0, `ADDR_AB_AE, 32'h0);
    chk(rd, 32'h2);
    $display("t_reset done");
  endtask
  task automatic t_ab;
    apb(1'b1, `ADDR_CTRL, 32'h0);
    apb(1'b1, `ADDR_DATA, 32'h10000);
    apb(1'b1, `ADDR_DATA, 32'h10001);
    fl(4'b1011);
    apb(1'b1, `ADDR_DATA, 32'h10002);
    fl(4'b1111);
    pb.op(3'b100, 18'h0);
    chk(32'(b_dout), 32'h10000);
    chk(32'(oe), 32'h1);
    pb.op(3'b110, 18'h0);
    chk(32'(b_dout), 32'h10000);
    pb.op(3'b101, 18'h0);
    chk(32'(b_dout), 32'h10001);
    chk(32'(oe), 32'h0);
    apb(1'b1, `ADDR_CTRL, 32'h8);
    pb.op(3'b100, 18'h0);
    chk(32'(b_dout), 32'h10002);
    fl(4'b0011);
    $display("t_ab done");
  endtask
  task automatic t_ba;
    apb(1'b1, `ADDR_CTRL, 32'h0);
    pb.op(3'b000, 18'h2aaaa);
    chk(32'(oe), 32'h0);
    pb.op(3'b001, 18'h15555);
    pb.op(3'b011, 18'h3ffff);
    chk(32'(ba_e), 32'h1);
    chk({28'h0, ba_e, ba_ae, ba_af, ba_f}, 32'hb);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(rd, 32'h1b3);
    apb(1'b0, `ADDR_DATA, 32'h0);
    chk(rd, 32'h2aaaa);
    apb(1'b0, `ADDR_DATA, 32'h0);
    chk(rd, 32'h15555);
    apb(1'b0, `ADDR_DATA, 32'h0);
    chk(rd, 32'h0);
    $display("t_ba done");
  endtask
  task automatic t_bypass;
    apb(1'b1, `ADDR_CTRL, {28'h0, `RES_BYPASS, 1'b0});
    pb.op(3'b111, 18'h0);
    chk(32'(byp_n), 32'h0);
    apb(1'b1, `ADDR_BYPASS, 32'h12345);
    pb.op(3'b100, 18'h0);
    chk(32'(b_dout), 32'h12345);
    pb.op(3'b001, 18'h0beef);
    apb(1'b0, `ADDR_BYPASS, 32'h0);
    chk(rd, 32'h0beef);
    apb(1'b1, `ADDR_BYPASS, 32'h30303);
    apb(1'b1, `ADDR_CTRL, 32'h1);
    pb.op(3'b100, 18'h0);
    chk(32'(b_dout), 32'h30303);
    chk(32'(byp_n), 32'h1);
    $display("t_bypass done");
  endtask
  task automatic t_full;
    apb(1'b1, `ADDR_CTRL, 32'h0);
    apb(1'b1, `ADDR_AB_AF, 32'h1);
    for (int i = 0; i < 254; i++)
      apb(1'b1, `ADDR_DATA, 32'(i));
    fl(4'b1111);
    apb(1'b1, `ADDR_DATA, 32'h0);
    fl(4'b1101);
    apb(1'b1, `ADDR_DATA, 32'h0);
    fl(4'b1100);
    $display("t_full done");
  endtask
  task automatic conclude;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run is about a thousand cycles; this allows roughly fifty times that
  initial
  begin
    #500000;
    miscompares++;
    conclude;
  end
  initial
  begin
    rst     = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h0;
    pwdata  = 32'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_ab;
    t_ba;
    t_bypass;
    t_full;
    conclude;
  end
endmodule // bififo_port_b_tb
bind bififo_port_b bififo_port_b_sva bififo_port_b_sva_i (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .PORT_B_CLOCK(PORT_B_CLOCK), .PORT_B_DIRECTION(PORT_B_DIRECTION),
  .PORT_B_WORD_ENABLE_N(PORT_B_WORD_ENABLE_N), .PORT_B_OUTPUT_DRIVE_N(PORT_B_OUTPUT_DRIVE_N),
  .PORT_B_DATA_OUT(PORT_B_DATA_OUT), .PORT_B_DATA_OE(PORT_B_DATA_OE), .AB_EMPTY_FLAG_N(AB_EMPTY_FLAG_N),
  .AB_ALMOST_EMPTY_FLAG_N(AB_ALMOST_EMPTY_FLAG_N), .AB_ALMOST_FULL_FLAG_N(AB_ALMOST_FULL_FLAG_N),
  .AB_FULL_FLAG_N(AB_FULL_FLAG_N), .BA_EMPTY_FLAG_N(BA_EMPTY_FLAG_N));
